/* File: hdl/strap_defines.svh */
// strap pin positions, default assignments and reset values
`ifndef STRAP_DEFINES_SVH
`define STRAP_DEFINES_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define STRAP_GPIO_W 10
`define STRAP_SEL_MIN_W 4
`define STRAP_CLK_OUT_W 12

// ----------------------------------------------------------------
// pin positions and default assignments
// ----------------------------------------------------------------
`define STRAP_PORT_SEL_PIN 9
`define STRAP_DEF_SEL_MASK 10'h00F

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define STRAP_RST_PINS 10'h3FF
`define STRAP_RST_CLK_OUT_EN 12'h000
`define STRAP_RST_GPIO_OE 10'h000
`define STRAP_RST_SEL_WORD 10'h000

`endif

/* File: hdl/strap_pkg.sv */
// types shared by the strap capture and configuration sequencer
`include "strap_defines.svh"

package strap_pkg;

  // ----------------------------------------------------------------
  // sequencer states and configuration sources
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_CAPTURE,
    ST_POWER,
    ST_INFO,
    ST_OTP,
    ST_EEPROM,
    ST_DONE
  } seq_state_t;

  typedef enum logic [1:0] {
    SRC_DEFAULT,
    SRC_OTP,
    SRC_EEPROM
  } cfg_source_t;

  // ----------------------------------------------------------------
  // complete state of the sequencer
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_state_t st;
    logic [`STRAP_GPIO_W-1:0] pins;
    logic port_is_i2c;
    logic address_bit_two;
    logic eeprom_skip;
    logic [`STRAP_GPIO_W-1:0] sel_word;
    logic [`STRAP_CLK_OUT_W-1:0] clk_out_en;
    logic [`STRAP_GPIO_W-1:0] gpio_oe;
    logic power_en;
    logic pll_cal_start;
    logic otp_req;
    logic eeprom_req;
    logic cfg_done;
    cfg_source_t source;
  } seq_regs_t;

endpackage : strap_pkg

/* File: hdl/strap_select_encoder.sv */
// decodes captured strap levels according to the pin function masks
`include "strap_defines.svh"

module strap_select_encoder (
  // captured straps
  input wire logic [`STRAP_GPIO_W-1:0] strap_pins,
  // pin function masks
  input wire logic [`STRAP_GPIO_W-1:0] sel_mask,
  input wire logic [`STRAP_GPIO_W-1:0] eeprom_mask,
  input wire logic [`STRAP_GPIO_W-1:0] addr_mask,
  // decoded values
  output logic [`STRAP_GPIO_W-1:0] sel_word,
  output logic eeprom_skip,
  output logic address_bit_two
);

  // ----------------------------------------------------------------
  // packs masked pins, lowest index to lsb
  // ----------------------------------------------------------------
  function automatic logic [`STRAP_GPIO_W-1:0] pack_pins(
    input logic [`STRAP_GPIO_W-1:0] pins,
    input logic [`STRAP_GPIO_W-1:0] mask
  );
    logic [`STRAP_GPIO_W-1:0] word;
    int unsigned k;
    word = '0;
    k = 0;
    for (int i = 0; i < `STRAP_GPIO_W; i++) begin
      if (mask[i]) begin
        word[k] = pins[i];
        k = k + 1;
      end
    end
    return word;
  endfunction : pack_pins

  logic [`STRAP_GPIO_W-1:0] eff_sel_mask;

  always_comb begin
    eff_sel_mask = (sel_mask == '0) ? `STRAP_DEF_SEL_MASK : sel_mask;
    sel_word = pack_pins(strap_pins, eff_sel_mask);
    eeprom_skip = |(strap_pins & eeprom_mask);
    address_bit_two = 1'b0;
    for (int i = 0; i < `STRAP_GPIO_W; i++) begin
      if (addr_mask[i]) begin
        address_bit_two = strap_pins[i];
      end
    end
  end

endmodule : strap_select_encoder

/* File: hdl/reset_strap_config_select.sv */
// strap capture at reset release and initial configuration sequencing
// ----------------------------------------------------------------
// Functional notes
// - capture strap pin levels at reset release and build initial setup from them
// - captured pin 9 low selects spi, high selects i2c
// - port and address strap settings stay writable later; selection and eeprom skip do not
// - address bit two is zero when no pin carries that function
// - several address pins: the highest-indexed one wins
// - address bit pin affects only a port selected as i2c
// - high eeprom-disable strap skips all external eeprom reads at startup
// - no eeprom-disable pin: eeprom search runs at its normal step
// - any high eeprom-disable pin disables; board should assign just one
// - no selection pins assigned: pins 3 to 0 form the selection
// - undriven pulled-up default pins select stored set 15
// - selection pins may be sparse; lowest index is lsb
// - device information may assign up to ten selection pins
// - fewer than four pins fill low bits, upper bits zero
// - more than four pins form a wider selection word
// - pin function assignment comes from device information; unprogrammed keeps defaults
// - stored configuration loaded later may replace address and port setup
// - defaults keep all clock outputs off and all gpio as inputs
// - after reset release: enable power, start pll calibration, wait for pll lock
// - setup comes from straps, stored memory, eeprom or defaults
// - loading sequence starts only at reset release
// - stored set with bad checksum: clock outputs and gpio return to defaults, port and address writes stay
// ----------------------------------------------------------------
`include "strap_defines.svh"

module reset_strap_config_select (
  // clock and master reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // strap pins
  input wire logic [`STRAP_GPIO_W-1:0] gpio_in,
  // device information from one-time memory
  input wire logic info_valid,
  input wire logic info_unprogrammed,
  input wire logic [`STRAP_GPIO_W-1:0] info_sel_mask,
  input wire logic [`STRAP_GPIO_W-1:0] info_eeprom_mask,
  input wire logic [`STRAP_GPIO_W-1:0] info_addr_mask,
  // power and pll bring-up
  input wire logic pll_locked,
  output logic power_en,
  output logic pll_cal_start,
  // stored configuration load from one-time memory
  output logic otp_load_req,
  output logic [`STRAP_GPIO_W-1:0] stored_config_set,
  input wire logic otp_load_done,
  input wire logic otp_checksum_ok,
  input wire logic otp_set_present,
  // external eeprom search
  output logic eeprom_search_req,
  input wire logic eeprom_search_done,
  input wire logic eeprom_found,
  // register writes from serial port or loader
  input wire logic cfg_wr,
  input wire logic cfg_port_is_i2c,
  input wire logic cfg_address_bit_two,
  input wire logic [`STRAP_CLK_OUT_W-1:0] cfg_clk_out_en,
  input wire logic [`STRAP_GPIO_W-1:0] cfg_gpio_oe,
  // resulting configuration and status
  output logic port_is_i2c,
  output logic address_bit_two,
  output logic eeprom_search_skip,
  output logic [`STRAP_CLK_OUT_W-1:0] clk_out_en,
  output logic [`STRAP_GPIO_W-1:0] gpio_oe,
  output logic config_done,
  output logic [1:0] config_source
);

  // ----------------------------------------------------------------
  // strap decode
  // ----------------------------------------------------------------
  strap_pkg::seq_regs_t cur_r;
  strap_pkg::seq_regs_t cur_nxt;
  logic [`STRAP_GPIO_W-1:0] dec_sel_word;
  logic dec_eeprom_skip;
  logic dec_addr_bit;
  logic [`STRAP_GPIO_W-1:0] use_sel_mask;
  logic [`STRAP_GPIO_W-1:0] use_eeprom_mask;
  logic [`STRAP_GPIO_W-1:0] use_addr_mask;

  always_comb begin
    if (info_unprogrammed) begin
      use_sel_mask = '0;
      use_eeprom_mask = '0;
      use_addr_mask = '0;
    end else begin
      use_sel_mask = info_sel_mask;
      use_eeprom_mask = info_eeprom_mask;
      use_addr_mask = info_addr_mask;
    end
  end

  strap_select_encoder u_encoder (
    .strap_pins(cur_r.pins),
    .sel_mask(use_sel_mask),
    .eeprom_mask(use_eeprom_mask),
    .addr_mask(use_addr_mask),
    .sel_word(dec_sel_word),
    .eeprom_skip(dec_eeprom_skip),
    .address_bit_two(dec_addr_bit)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.pll_cal_start = 1'b0;
    cur_nxt.otp_req = 1'b0;
    cur_nxt.eeprom_req = 1'b0;
    case (cur_r.st)
      strap_pkg::ST_CAPTURE: begin
        cur_nxt.pins = gpio_in;
        cur_nxt.port_is_i2c = gpio_in[`STRAP_PORT_SEL_PIN];
        cur_nxt.power_en = 1'b1;
        cur_nxt.pll_cal_start = 1'b1;
        cur_nxt.st = strap_pkg::ST_POWER;
      end
      strap_pkg::ST_POWER: begin
        if (pll_locked) begin
          cur_nxt.st = strap_pkg::ST_INFO;
        end
      end
      strap_pkg::ST_INFO: begin
        if (info_valid) begin
          cur_nxt.address_bit_two = cur_r.port_is_i2c & dec_addr_bit;
          cur_nxt.eeprom_skip = dec_eeprom_skip;
          cur_nxt.sel_word = dec_sel_word;
          if (!info_unprogrammed) begin
            cur_nxt.otp_req = 1'b1;
            cur_nxt.st = strap_pkg::ST_OTP;
          end else if (!dec_eeprom_skip) begin
            cur_nxt.eeprom_req = 1'b1;
            cur_nxt.st = strap_pkg::ST_EEPROM;
          end else begin
            cur_nxt.st = strap_pkg::ST_DONE;
          end
        end
      end
      strap_pkg::ST_OTP: begin
        if (otp_load_done) begin
          if (otp_set_present && otp_checksum_ok) begin
            cur_nxt.source = strap_pkg::SRC_OTP;
          end else begin
            cur_nxt.clk_out_en = `STRAP_RST_CLK_OUT_EN;
            cur_nxt.gpio_oe = `STRAP_RST_GPIO_OE;
          end
          if (cur_r.eeprom_skip) begin
            cur_nxt.st = strap_pkg::ST_DONE;
          end else begin
            cur_nxt.eeprom_req = 1'b1;
            cur_nxt.st = strap_pkg::ST_EEPROM;
          end
        end
      end
      strap_pkg::ST_EEPROM: begin
        if (eeprom_search_done) begin
          if (eeprom_found) begin
            cur_nxt.source = strap_pkg::SRC_EEPROM;
          end
          cur_nxt.st = strap_pkg::ST_DONE;
        end
      end
      strap_pkg::ST_DONE: begin
        cur_nxt.cfg_done = 1'b1;
      end
      default: begin
        cur_nxt.st = strap_pkg::ST_DONE;
      end
    endcase
    if (cfg_wr && (cur_r.st != strap_pkg::ST_CAPTURE)) begin
      cur_nxt.port_is_i2c = cfg_port_is_i2c;
      cur_nxt.address_bit_two = cfg_address_bit_two;
      cur_nxt.clk_out_en = cfg_clk_out_en;
      cur_nxt.gpio_oe = cfg_gpio_oe;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_r.st <= strap_pkg::ST_CAPTURE;
      cur_r.pins <= `STRAP_RST_PINS;
      cur_r.port_is_i2c <= 1'b0;
      cur_r.address_bit_two <= 1'b0;
      cur_r.eeprom_skip <= 1'b0;
      cur_r.sel_word <= `STRAP_RST_SEL_WORD;
      cur_r.clk_out_en <= `STRAP_RST_CLK_OUT_EN;
      cur_r.gpio_oe <= `STRAP_RST_GPIO_OE;
      cur_r.power_en <= 1'b0;
      cur_r.pll_cal_start <= 1'b0;
      cur_r.otp_req <= 1'b0;
      cur_r.eeprom_req <= 1'b0;
      cur_r.cfg_done <= 1'b0;
      cur_r.source <= strap_pkg::SRC_DEFAULT;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign power_en = cur_r.power_en;
  assign pll_cal_start = cur_r.pll_cal_start;
  assign otp_load_req = cur_r.otp_req;
  assign stored_config_set = cur_r.sel_word;
  assign eeprom_search_req = cur_r.eeprom_req;
  assign port_is_i2c = cur_r.port_is_i2c;
  assign address_bit_two = cur_r.address_bit_two;
  assign eeprom_search_skip = cur_r.eeprom_skip;
  assign clk_out_en = cur_r.clk_out_en;
  assign gpio_oe = cur_r.gpio_oe;
  assign config_done = cur_r.cfg_done;
  assign config_source = cur_r.source;

endmodule : reset_strap_config_select

/* File: verif/strap_config_properties.sv */
// checker for strap capture and configuration sequencing
module strap_config_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // inputs
  input wire logic [9:0] gpio_in,
  input wire logic info_unprogrammed,
  input wire logic cfg_wr,
  input wire logic cfg_port_is_i2c,
  input wire logic [11:0] cfg_clk_out_en,
  input wire logic [9:0] cfg_gpio_oe,
  // outputs
  input wire logic power_en,
  input wire logic pll_cal_start,
  input wire logic otp_load_req,
  input wire logic eeprom_search_req,
  input wire logic eeprom_search_skip,
  input wire logic port_is_i2c,
  input wire logic [11:0] clk_out_en,
  input wire logic [9:0] gpio_oe,
  input wire logic config_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  AST_PLL: assert property ($rose(reset_n) |=> power_en && pll_cal_start ##1 !pll_cal_start)
    else $error("pll start");
  AST_PORT: assert property ($rose(reset_n) |=> port_is_i2c == $past(gpio_in[9]))
    else $error("port select");
  AST_DEF: assert property ($rose(reset_n) |=> clk_out_en == 12'h000 && gpio_oe == 10'h000)
    else $error("defaults");
  AST_WR: assert property (cfg_wr && !$rose(reset_n) |=> port_is_i2c == $past(cfg_port_is_i2c)
    && clk_out_en == $past(cfg_clk_out_en) && gpio_oe == $past(cfg_gpio_oe)) else $error("write");
  AST_HOLD: assert property (!cfg_wr && !$rose(reset_n) |=> $stable(port_is_i2c))
    else $error("port hold");
  AST_SKIP: assert property (eeprom_search_skip |-> !eeprom_search_req)
    else $error("skip");
  AST_UNPROG: assert property (otp_load_req |-> !info_unprogrammed)
    else $error("unprogrammed");
  AST_SEQ: assert property (otp_load_req |-> ##[1:100] config_done)
    else $error("sequence");
  AST_DONE: assert property (config_done |=> config_done)
    else $error("done");
  cover property (otp_load_req);
  cover property (eeprom_search_req);
  cover property (config_done && eeprom_search_skip);
endmodule : strap_config_properties

bind reset_strap_config_select strap_config_properties u_strap_config_properties (.sys_clk, .reset_n,
  .gpio_in, .info_unprogrammed, .cfg_wr, .cfg_port_is_i2c, .cfg_clk_out_en, .cfg_gpio_oe, .power_en,
  .pll_cal_start, .otp_load_req, .eeprom_search_req, .eeprom_search_skip, .port_is_i2c, .clk_out_en,
  .gpio_oe, .config_done);

/* File: verif/strap_board_model.sv */
// board straps with pull-ups, stored memory loader and eeprom responder
module strap_board_model (
  // clock
  input wire logic sys_clk,
  // strap levels and answer setup
  input wire logic [9:0] s_drv,
  input wire logic [9:0] s_val,
  input wire logic [3:0] lat,
  input wire logic ok,
  input wire logic found_en,
  // requests
  input wire logic otp_load_req,
  input wire logic eeprom_search_req,
  // answers
  output logic [9:0] gpio_in,
  output logic otp_load_done,
  output logic otp_checksum_ok,
  output logic otp_set_present,
  output logic eeprom_search_done,
  output logic eeprom_found
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] oc = 4'h0;
  logic [3:0] ec = 4'h0;
  assign gpio_in = (s_drv & s_val) | ~s_drv;
  always @(posedge sys_clk) begin
    oc <= otp_load_req ? lat : oc - {3'h0, oc != 4'h0};
    ec <= eeprom_search_req ? lat : ec - {3'h0, ec != 4'h0};
  end
  assign otp_load_done = oc == 4'h1;
  assign otp_checksum_ok = otp_load_done ? ok : ~ok;
  assign otp_set_present = otp_load_done;
  assign eeprom_search_done = ec == 4'h1;
  assign eeprom_found = eeprom_search_done & found_en;
endmodule : strap_board_model

/* File: verif/reset_strap_config_select_bench.sv */
// self-checking bench for strap capture and configuration sequencing
module reset_strap_config_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, reset_n = 1'b0, info_valid = 1'b0, info_unprogrammed = 1'b0, pll_locked = 1'b0;
  logic ok = 1'b1, cfg_wr = 1'b0, cfg_port_is_i2c = 1'b0, cfg_address_bit_two = 1'b0;
  logic [9:0] s_drv = '0, s_val = '0, info_sel_mask = '0, info_eeprom_mask = '0;
  logic [9:0] info_addr_mask = '0, cfg_gpio_oe = '0;
  logic [11:0] cfg_clk_out_en = '0;
  logic [3:0] lat = 4'h1;
  logic found_en = 1'b0;
  logic [9:0] gpio_in, stored_config_set, gpio_oe;
  logic [11:0] clk_out_en;
  logic [1:0] config_source;
  logic power_en, pll_cal_start, otp_load_req, otp_load_done, otp_checksum_ok, otp_set_present;
  logic eeprom_search_req, eeprom_search_done, eeprom_found, port_is_i2c, address_bit_two;
  logic eeprom_search_skip, config_done;
  int bad_count = 0, checked = 0, n_otp = 0, n_eep = 0, tn = 0;
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    n_otp += otp_load_req;
    n_eep += eeprom_search_req;
  end
  reset_strap_config_select u_reset_strap_config_select (.sys_clk, .reset_n, .gpio_in, .info_valid,
    .info_unprogrammed, .info_sel_mask, .info_eeprom_mask, .info_addr_mask, .pll_locked, .power_en,
    .pll_cal_start, .otp_load_req, .stored_config_set, .otp_load_done, .otp_checksum_ok, .otp_set_present,
    .eeprom_search_req, .eeprom_search_done, .eeprom_found, .cfg_wr, .cfg_port_is_i2c, .cfg_address_bit_two,
    .cfg_clk_out_en, .cfg_gpio_oe, .port_is_i2c, .address_bit_two, .eeprom_search_skip, .clk_out_en,
    .gpio_oe, .config_done, .config_source);
  strap_board_model u_strap_board_model (.sys_clk, .s_drv, .s_val, .lat, .ok, .found_en, .otp_load_req,
    .eeprom_search_req, .gpio_in, .otp_load_done, .otp_checksum_ok, .otp_set_present,
    .eeprom_search_done, .eeprom_found);
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // strap a board, reset, run the sequence, then wiggle every pin
  task automatic boot(input logic [9:0] drv, val, sm, em, am, input logic unp, good);
    @(negedge sys_clk);
    reset_n = 1'b0;
    info_valid = 1'b0;
    pll_locked = 1'b0;
    s_drv = drv;
    s_val = val;
    info_sel_mask = sm;
    info_eeprom_mask = em;
    info_addr_mask = am;
    info_unprogrammed = unp;
    ok = good;
    n_otp = 0;
    n_eep = 0;
    repeat (4) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    pll_locked = 1'b1;
    info_valid = 1'b1;
    for (int i = 0; i < 200 && config_done !== 1'b1; i++) @(negedge sys_clk);
    s_val = ~gpio_in;
    s_drv = '1;
    repeat (2) @(negedge sys_clk);
  endtask : boot
  task automatic exp_cfg(input logic p, a, sk, input logic [9:0] sel, input int no, ne, input logic [1:0] src);
    chk(12'(port_is_i2c), 12'(p), "port");
    chk(12'(address_bit_two), 12'(a), "addr");
    chk(12'(eeprom_search_skip), 12'(sk), "skip");
    chk(12'(stored_config_set), 12'(sel), "set");
    chk(12'(n_otp), 12'(no), "otp req");
    chk(12'(n_eep), 12'(ne), "eeprom req");
    chk(12'(config_source), 12'(src), "source");
    chk(clk_out_en, 12'h000, "clk out");
    chk(12'(gpio_oe), 12'h000, "gpio oe");
    chk(12'(config_done), 12'h001, "done");
    tn++;
    $display("test %0d end, mismatches %0d", tn, bad_count);
  endtask : exp_cfg
  task automatic wr(input logic p, a, input logic [11:0] c, input logic [9:0] g);
    cfg_port_is_i2c = p;
    cfg_address_bit_two = a;
    cfg_clk_out_en = c;
    cfg_gpio_oe = g;
    cfg_wr = 1'b1;
    @(negedge sys_clk);
    chk(12'(port_is_i2c), 12'(p), "wr port");
    chk(12'(address_bit_two), 12'(a), "wr addr");
    chk(clk_out_en, c, "wr clk");
    chk(12'(gpio_oe), 12'(g), "wr oe");
  endtask : wr
  initial begin
    #40000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    boot(10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 1'b0, 1'b1);
    exp_cfg(1'b1, 1'b0, 1'b0, 10'h00F, 1, 1, 2'h1);
    lat = 4'h9;
    boot(10'h166, 10'h104, 10'h124, 10'h0C0, 10'h012, 1'b0, 1'b0);
    exp_cfg(1'b1, 1'b1, 1'b1, 10'h005, 1, 0, 2'h0);
    boot(10'h21F, 10'h016, 10'h01F, 10'h000, 10'h020, 1'b0, 1'b1);
    exp_cfg(1'b0, 1'b0, 1'b0, 10'h016, 1, 1, 2'h1);
    found_en = 1'b1;
    boot(10'h000, 10'h000, 10'h0F0, 10'h200, 10'h001, 1'b1, 1'b1);
    exp_cfg(1'b1, 1'b0, 1'b0, 10'h00F, 0, 1, 2'h2);
    wr(1'b0, 1'b1, 12'hABC, 10'h155);
    wr(1'b1, 1'b0, 12'h543, 10'h2AA);
    cfg_wr = 1'b0;
    $display("write test end, mismatches %0d", bad_count);
    report_and_stop;
  end
endmodule : reset_strap_config_select_bench
